// >>> flc_core_model.sv
// Purpose: Core model taking grants and ending service
// Assumes: Changes outputs just after a rising edge
// Notes:   Ack delay and service end are steered by the bench
module flc_core_model (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire flc_pkg::flc_grant_t grant,
  input  wire logic [3:0]          in_service,
  input  wire logic [1:0]          ack_dly,
  input  wire logic                serve,
  input  wire logic                stray,
  output      logic                cpu_ack,
  output      logic                cpu_reti
);
  logic [1:0] wait_cnt;

  // ---------------------------------------------------------------
  // A slow core leaves the offer standing for up to three cycles
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (grant.valid && !cpu_ack && wait_cnt == ack_dly) begin
      cpu_ack  <= 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      cpu_ack  <= 1'b0;
      wait_cnt <= (grant.valid && !cpu_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_reti <= 1'b0;
    end else begin
      // Stray lets the bench send a return with nothing in service
      cpu_reti <= ((serve && in_service != 4'h0) || stray) && !cpu_reti;
    end
  end
endmodule : flc_core_model

// >>> flc_ctrl.sv
// Purpose: Six-source, four-level nesting interrupt controller
// Assumes: Timer and serial requests come from logic on sys_clk;
//          the two external pins are asynchronous and active low
// Notes:   The core acknowledges a request with cpu_ack and ends
//          service with cpu_reti; it clears the source flag itself
`include "flc_params.svh"

// Operation
// - Six sources: two external pins, three timer overflows, serial port.
// - Each source gated by its own enable bit; masked never granted.
// - Enable bit 7 global: zero blocks all, one defers to own bits.
// - Level of a source joins its low and high priority bits.
// - Level is high bit then low bit; 0 lowest, 3 highest.
// - Service preempted only by strictly higher level; others wait.
// - Service at level 3 is never preempted.
// - Simultaneous different levels: higher level granted.
// - Equal levels: fixed polling order picks the winner.
// - Enable bits 5..0: timer c, serial, timer b, ext b, timer a, ext a.
// - Low priority bits use same positions; bits 7 and 6 reserved.
// - Enable resets to zero, all masked; single-bit access supported.
module flc_ctrl #(
  parameter int N_SRC  = 6,
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output      logic [7:0]        rd_data,
  input  wire logic              ext_pin_req_a_n,
  input  wire logic              ext_pin_req_b_n,
  input  wire logic              timer_a_ovf,
  input  wire logic              timer_b_ovf,
  input  wire logic              timer_c_ovf,
  input  wire logic              serial_req,
  input  wire logic              cpu_ack,
  input  wire logic              cpu_reti,
  output flc_pkg::flc_grant_t    grant,
  output      logic [3:0]        in_service,
  output      logic              irq
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (N_SRC != 6) begin : g_bad_src
    $error("flc_ctrl serves exactly six sources");
  end
  if (ADDR_W != 8) begin : g_bad_addr
    $error("flc_ctrl decodes an eight-bit address");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic                 global_irq_enable;
  logic [N_SRC-1:0]     src_en;
  logic [N_SRC-1:0]     prio_low;
  logic [N_SRC-1:0]     prio_high;
  logic [2:0]           evt_stat;
  logic [2:0]           evt_mask;

  // Named views of the enable and low priority fields
  logic timer_c_irq_enable;
  logic serial_irq_enable;
  logic timer_b_irq_enable;
  logic ext_b_irq_enable;
  logic timer_a_irq_enable;
  logic ext_a_irq_enable;
  assign {timer_c_irq_enable, serial_irq_enable, timer_b_irq_enable,
          ext_b_irq_enable, timer_a_irq_enable, ext_a_irq_enable}
         = src_en;

  logic timer_c_prio_low;
  logic serial_prio_low;
  logic timer_b_prio_low;
  logic ext_b_prio_low;
  logic timer_a_prio_low;
  logic ext_a_prio_low;
  assign {timer_c_prio_low, serial_prio_low, timer_b_prio_low,
          ext_b_prio_low, timer_a_prio_low, ext_a_prio_low}
         = prio_low;

  // ---------------------------------------------------------------
  // External pin synchronisers
  // ---------------------------------------------------------------
  // Pins are low active; a change counts once stages two and three agree
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       ext_pin_req_a;
  logic       ext_pin_req_b;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {sync_a[1:0], ext_pin_req_a_n};
      sync_b <= {sync_b[1:0], ext_pin_req_b_n};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_pin_req_a <= 1'b0;
      ext_pin_req_b <= 1'b0;
    end else begin
      if (sync_a[1] == sync_a[2]) begin
        ext_pin_req_a <= ~sync_a[2];
      end
      if (sync_b[1] == sync_b[2]) begin
        ext_pin_req_b <= ~sync_b[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Source gathering and levels
  // ---------------------------------------------------------------
  flc_pkg::flc_src_t     src;
  logic [N_SRC-1:0]      pending;
  flc_pkg::flc_level_t   src_level [N_SRC];

  // Bit index equals polling position, so lower index polls first
  assign src.ext_a   = ext_pin_req_a;
  assign src.timer_a = timer_a_ovf;
  assign src.ext_b   = ext_pin_req_b;
  assign src.timer_b = timer_b_ovf;
  assign src.serial  = serial_req;
  assign src.timer_c = timer_c_ovf;

  // Masked or globally disabled sources never reach arbitration
  assign pending = global_irq_enable ? (src & src_en) : '0;

  for (genvar i = 0; i < N_SRC; i++) begin : g_level
    assign src_level[i] = {prio_high[i], prio_low[i]};
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  logic                in_any;
  flc_pkg::flc_level_t act_level;
  logic                found;
  flc_pkg::flc_vec_t   best_vec;
  flc_pkg::flc_level_t best_level;

  // Level of the deepest nested service still open
  always_comb begin
    in_any    = |in_service;
    act_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service[l]) begin
        act_level = 2'(l);
      end
    end
  end

  // Strict greater-than also shuts out everything at the top level
  always_comb begin
    found      = 1'b0;
    best_vec   = 3'h0;
    best_level = 2'h0;
    for (int i = 0; i < N_SRC; i++) begin
      if (pending[i] && (!in_any || src_level[i] > act_level)
          && (!found || src_level[i] > best_level)) begin
        found      = 1'b1;
        best_vec   = 3'(i);
        best_level = src_level[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Request to the core
  // ---------------------------------------------------------------
  logic taken;
  assign taken = grant.valid && cpu_ack;

  // Dropped for one cycle after an acknowledge so that the stack
  // settles before the next winner is offered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      grant <= '0;
    end else if (taken) begin
      grant.valid <= 1'b0;
    end else begin
      grant.valid <= found;
      grant.vec   <= best_vec;
      grant.level <= best_level;
    end
  end

  // ---------------------------------------------------------------
  // In-service stack
  // ---------------------------------------------------------------
  logic [3:0] next_in_service;

  // One bit per level suffices: a level can be open only once
  always_comb begin
    next_in_service = in_service;
    if (cpu_reti && in_any) begin
      next_in_service[act_level] = 1'b0;
    end
    if (taken) begin
      next_in_service[grant.level] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable <= 1'b0;
      src_en            <= '0;
    end else if (wr_en) begin
      if (addr == `FLC_ADDR_ENABLE) begin
        global_irq_enable <= wr_data[`FLC_GLOBAL_BIT];
        src_en            <= wr_data[`FLC_SRC_MSB:0];
      end else if (addr == `FLC_ADDR_EN_SET) begin
        // Set and clear ports let software touch one bit alone
        global_irq_enable <= global_irq_enable
                             | wr_data[`FLC_GLOBAL_BIT];
        src_en            <= src_en | wr_data[`FLC_SRC_MSB:0];
      end else if (addr == `FLC_ADDR_EN_CLR) begin
        global_irq_enable <= global_irq_enable
                             & ~wr_data[`FLC_GLOBAL_BIT];
        src_en            <= src_en & ~wr_data[`FLC_SRC_MSB:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prio_low  <= `FLC_PRIO_RST;
      prio_high <= `FLC_PRIO_RST;
    end else if (wr_en) begin
      // Reserved bits are not stored, so they cannot disturb levels
      if (addr == `FLC_ADDR_PRIO_LOW) begin
        prio_low  <= wr_data[`FLC_SRC_MSB:0];
      end else if (addr == `FLC_ADDR_PRIO_HIGH) begin
        prio_high <= wr_data[`FLC_SRC_MSB:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status and interrupt line
  // ---------------------------------------------------------------
  logic [2:0] evt_set;
  logic       stat_wr;

  assign evt_set[`FLC_EVT_GRANT]   = taken;
  assign evt_set[`FLC_EVT_NEST]    = taken && in_any;
  assign evt_set[`FLC_EVT_BAD_RET] = cpu_reti && !in_any;
  assign stat_wr = wr_en && (addr == `FLC_ADDR_EVT_STAT);

  // A new event wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_stat <= `FLC_EVT_RST;
    end else if (stat_wr) begin
      evt_stat <= (evt_stat & ~wr_data[2:0]) | evt_set;
    end else begin
      evt_stat <= evt_stat | evt_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_mask <= `FLC_EVT_RST;
    end else if (wr_en && addr == `FLC_ADDR_EVT_MASK) begin
      evt_mask <= wr_data[2:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat & evt_mask);
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;

  // Reserved bits read as zero; unmapped offsets read as zero
  always_comb begin
    if (addr == `FLC_ADDR_ENABLE || addr == `FLC_ADDR_EN_SET
        || addr == `FLC_ADDR_EN_CLR) begin
      rd_mux = {global_irq_enable, 1'b0, src_en};
    end else if (addr == `FLC_ADDR_PRIO_LOW) begin
      rd_mux = {2'h0, prio_low};
    end else if (addr == `FLC_ADDR_PRIO_HIGH) begin
      rd_mux = {2'h0, prio_high};
    end else if (addr == `FLC_ADDR_EVT_STAT) begin
      rd_mux = {5'h00, evt_stat};
    end else if (addr == `FLC_ADDR_EVT_MASK) begin
      rd_mux = {5'h00, evt_mask};
    end else begin
      rd_mux = `FLC_RD_UNMAPPED;
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : flc_ctrl

// >>> flc_params.svh
// Purpose: Register map and field positions of the interrupt controller
// Assumes: Eight-bit register port, one clock domain
// Notes:   Included by the controller, the port checks and the bench
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FLC_ADDR_ENABLE    8'ha8
`define FLC_ADDR_PRIO_HIGH 8'hb7
`define FLC_ADDR_PRIO_LOW  8'hb8
`define FLC_ADDR_EN_SET    8'hc2
`define FLC_ADDR_EN_CLR    8'hc3
`define FLC_ADDR_EVT_STAT  8'hc4
`define FLC_ADDR_EVT_MASK  8'hc5

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define FLC_GLOBAL_BIT     7
`define FLC_SRC_MSB        5
`define FLC_ENABLE_RST     8'h00
`define FLC_PRIO_RST       6'h00
`define FLC_EVT_RST        3'h0
`define FLC_EVT_GRANT      0
`define FLC_EVT_NEST       1
`define FLC_EVT_BAD_RET    2
`define FLC_TOP_LEVEL      2'h3
`define FLC_RD_UNMAPPED    8'h00

`endif

// >>> flc_pkg.sv
// Purpose: Types shared by the interrupt controller and its users
// Assumes: Six sources, four levels
// Notes:   Constants live in flc_params.svh
package flc_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [1:0] flc_level_t;
  typedef logic [2:0] flc_vec_t;

  // Request to the core: vector and level travel together
  typedef struct packed {
    logic       valid;
    flc_vec_t   vec;
    flc_level_t level;
  } flc_grant_t;

  // Source request lines in polling order
  typedef struct packed {
    logic timer_c;
    logic serial;
    logic timer_b;
    logic ext_b;
    logic timer_a;
    logic ext_a;
  } flc_src_t;

endpackage : flc_pkg

// >>> flc_props.sv
// Purpose: Port checks for the interrupt controller
// Assumes: One clock, rst asynchronous and active high
// Notes:   Bound to flc_ctrl from the bench top file
`include "flc_params.svh"
module flc_props #(
  parameter int ADDR_W = 8
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic [ADDR_W-1:0]   addr,
  input wire logic [7:0]          wr_data,
  input wire logic                wr_en,
  input wire logic                rd_en,
  input wire logic [7:0]          rd_data,
  input wire logic                cpu_ack,
  input wire logic                cpu_reti,
  input wire flc_pkg::flc_grant_t grant,
  input wire logic [3:0]          in_service
);
  logic       glob;
  logic [1:0] top_lvl;

  // ---------------------------------------------------------------
  // Helpers: global enable copy, deepest level in service
  // ---------------------------------------------------------------
  assign top_lvl = in_service[3] ? 2'h3 : in_service[2] ? 2'h2 :
                   in_service[1] ? 2'h1 : 2'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      glob <= 1'b0;
    end else if (wr_en && addr == `FLC_ADDR_ENABLE) begin
      glob <= wr_data[7];
    end else if (wr_en && addr == `FLC_ADDR_EN_SET && wr_data[7]) begin
      glob <= 1'b1;
    end else if (wr_en && addr == `FLC_ADDR_EN_CLR && wr_data[7]) begin
      glob <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_global_gate: assert property (
    !glob && !$past(glob) |-> !grant.valid)
    else $error("grant offered with global enable off");
  a_top_blocks: assert property (
    in_service[3] |-> !grant.valid)
    else $error("grant offered during top level service");
  a_strict_higher: assert property (
    grant.valid && in_service != 4'h0 |-> grant.level > top_lvl)
    else $error("grant not above level in service");
  a_ack_pushes: assert property (
    cpu_ack && grant.valid |=>
      !grant.valid && in_service[$past(grant.level)])
    else $error("ack did not enter service");
  a_reti_pops: assert property (
    cpu_reti && !cpu_ack |=>
      in_service == ($past(in_service) & ~(4'h1 << $past(top_lvl))))
    else $error("return did not clear deepest level");
  a_grant_vec: assert property (
    grant.valid |-> grant.vec <= 3'h5)
    else $error("grant vector out of range");
  a_prio_reserved: assert property (
    rd_en && addr == `FLC_ADDR_PRIO_LOW |=> rd_data[7:6] == 2'h0)
    else $error("priority reserved bits read nonzero");
  a_en_reserved: assert property (
    rd_en && addr == `FLC_ADDR_ENABLE |=> rd_data[6] == 1'b0)
    else $error("enable reserved bit read nonzero");
  a_rd_single: assert property (
    !$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
endmodule : flc_props

// >>> test_four_level_interrupt_ctrl.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model acks offers; bench drives sources and registers
// Notes:   Expected reads and grants queue up; a monitor pops them
`include "flc_params.svh"
module test_four_level_interrupt_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk, rst, wr_en, rd_en, serve, cpu_ack;
  logic                cpu_reti, irq, rd_was, stray;
  logic [7:0]          addr, wr_data, rd_data, v;
  logic [1:0]          ack_dly;
  logic [3:0]          in_service;
  flc_pkg::flc_src_t   req;
  flc_pkg::flc_grant_t grant;
  logic [7:0]          exp_rd[$];
  logic [4:0]          exp_gr[$];
  int                  fails, n_compared, cyc, s;

  flc_ctrl flc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ext_pin_req_a_n(~req.ext_a), .ext_pin_req_b_n(~req.ext_b),
    .timer_a_ovf(req.timer_a), .timer_b_ovf(req.timer_b),
    .timer_c_ovf(req.timer_c), .serial_req(req.serial),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .grant(grant),
    .in_service(in_service), .irq(irq));
  flc_core_model flc_core_model_inst (.sys_clk(sys_clk), .rst(rst),
    .grant(grant), .in_service(in_service), .ack_dly(ack_dly),
    .serve(serve), .stray(stray), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e, got);
    n_compared++;
    if (e !== got) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_rd.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask : rd
  // Waits out the pin synchronisers so a dropped pin cannot re-request
  task automatic serv(input logic [5:0] src, input logic [2:0] vec,
                      input logic [1:0] lvl);
    exp_gr.push_back({vec, lvl});
    ack_dly <= 2'($urandom);
    // Pins lag the timers by their four-cycle filter, so they lead here
    @(posedge sys_clk) req <= src & 6'h05;
    repeat (4) @(posedge sys_clk);
    req <= src;
    @(posedge sys_clk);
    for (int i = 0; i < 40 && !(cpu_ack && grant.valid); i++)
      @(posedge sys_clk);
    if (!(cpu_ack && grant.valid)) chk("ack", 8'h01, 8'h00);
    req <= 6'h00;
    repeat (8) @(posedge sys_clk);
  endtask : serv
  task automatic quiet(input logic [5:0] src);
    @(posedge sys_clk) req <= src;
    repeat (12) begin
      @(posedge sys_clk);
      chk("grant valid", 8'h00, {7'h0, grant.valid});
    end
    req <= 6'h00;
    repeat (8) @(posedge sys_clk);
  endtask : quiet
  task automatic unwind();
    serve <= 1'b1;
    repeat (10) @(posedge sys_clk);
    serve <= 1'b0;
  endtask : unwind

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (rd_was) chk("rd_data", exp_rd.size() ? exp_rd.pop_front() : 'x,
                    rd_data);
    rd_was = rd_en;
    if (cpu_ack === 1'b1 && grant.valid === 1'b1)
      chk("grant", exp_gr.size() ? {3'h0, exp_gr.pop_front()} : 'x,
          {3'h0, grant.vec, grant.level});
    if (++cyc > 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    {rst, wr_en, rd_en, serve, rd_was, stray} = 6'h20;
    {addr, wr_data, req, ack_dly} = '0;
    void'($urandom(32'hfb41));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`FLC_ADDR_ENABLE, 8'h00);
    rd(8'h10, `FLC_RD_UNMAPPED);
    v = 8'($urandom) & 8'hbf;
    wr(`FLC_ADDR_ENABLE, v);
    rd(`FLC_ADDR_ENABLE, v);
    wr(`FLC_ADDR_PRIO_LOW, v & 8'h3f);
    rd(`FLC_ADDR_PRIO_LOW, v & 8'h3f);
    wr(`FLC_ADDR_ENABLE, 8'h00);
    wr(`FLC_ADDR_EN_SET, 8'h05);
    wr(`FLC_ADDR_EN_CLR, 8'h01);
    rd(`FLC_ADDR_ENABLE, 8'h04);
    wr(`FLC_ADDR_PRIO_LOW, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(`FLC_ADDR_ENABLE, 8'h80 | (8'h01 << i));
      serv(6'h3f, 3'(i), 2'h0);
      unwind();
    end
    wr(`FLC_ADDR_ENABLE, 8'hbf);
    for (int k = 0; k < 6; k++) begin
      serv(6'h3f << k, 3'(k), 2'h0);
      unwind();
    end
    for (int lv = 1; lv < 4; lv++) begin
      s = $urandom % 6;
      wr(`FLC_ADDR_PRIO_HIGH, 8'(lv >> 1) << s);
      wr(`FLC_ADDR_PRIO_LOW, 8'(lv & 1) << s);
      serv(6'h3f, 3'(s), 2'(lv));
      unwind();
    end
    wr(`FLC_ADDR_PRIO_HIGH, 8'h38);
    wr(`FLC_ADDR_PRIO_LOW, 8'h36);
    serv(6'h02, 3'h1, 2'h1);
    quiet(6'h05);
    serv(6'h08, 3'h3, 2'h2);
    serv(6'h10, 3'h4, 2'h3);
    quiet(6'h2f);
    unwind();
    wr(`FLC_ADDR_ENABLE, 8'h3f);
    quiet(6'h3f);
    wr(`FLC_ADDR_EN_SET, 8'h80);
    serv(6'h3f, 3'h4, 2'h3);
    unwind();
    // A return with nothing in service must raise its event bit
    stray <= 1'b1;
    @(posedge sys_clk);
    stray <= 1'b0;
    wr(`FLC_ADDR_EVT_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(`FLC_ADDR_EVT_STAT, 8'h07);
    wr(`FLC_ADDR_EVT_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq", 8'h01, {7'h0, irq});
    wr(`FLC_ADDR_EVT_STAT, 8'h07);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    rd(`FLC_ADDR_EVT_STAT, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("notes left", 8'h00, 8'(exp_rd.size() + exp_gr.size()));
    wrap_up();
  end
endmodule : test_four_level_interrupt_ctrl

bind flc_ctrl flc_props #(.ADDR_W(ADDR_W)) flc_props_inst (
  .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cpu_ack(cpu_ack),
  .cpu_reti(cpu_reti), .grant(grant), .in_service(in_service));
